/* File: inc/mair_pkg.sv */
// mair_pkg: register map, field layout, reset values and input numbering of the manual analog input route control.
// assumes a byte-wide register file reached over 32-bit classic Wishbone, one register per aligned word.
package mair_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_SEL01 = 8'hc3;
  localparam logic [7:0] IDX_EN_SEL2 = 8'hc4;
  localparam logic [7:0] IDX_SEL3 = 8'hf3;
  localparam logic [7:0] IDX_ROUTE_STATUS = 8'hf4;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_SEL01 = {IDX_SEL01, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EN_SEL2 = {IDX_EN_SEL2, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SEL3 = {IDX_SEL3, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ROUTE_STATUS = {IDX_ROUTE_STATUS, 2'h0};

  // field positions
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 4;
  localparam int SEL2_LSB = 0;
  localparam int MAN_EN_BIT = 7;
  localparam int SEL3_LSB = 4;
  localparam int SEL_W = 4;
  localparam int NUM_CONV = 4;
  localparam int PIN_W = 4;

  // reset values
  localparam logic [7:0] RST_SEL01 = 8'h00;
  localparam logic [7:0] RST_EN_SEL2 = 8'h00;
  localparam logic [7:0] RST_SEL3 = 8'h00;

  // writable bit masks; reserved bits read zero
  localparam logic [7:0] MASK_SEL01 = 8'hff;
  localparam logic [7:0] MASK_EN_SEL2 = 8'h8f;
  localparam logic [7:0] MASK_SEL3 = 8'hf0;

  // analog input numbers; 0 means no connection
  localparam logic [PIN_W-1:0] PIN_NONE = 4'h0;

  typedef enum logic [1:0] {
    MAIR_CONV0,
    MAIR_CONV1,
    MAIR_CONV2,
    MAIR_CONV3
  } mair_conv_t;

endpackage

/* File: rtl/mair_route_decode.sv */
// mair_route_decode: one converter's input switch decode, select code to analog input number.
// assumes select code is stable register output of the same clock; output is registered.
`timescale 1ns/100ps
module mair_route_decode #(
  parameter int CONV = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic manualEn,
  input wire logic [mair_pkg::SEL_W-1:0] selCode,
  output logic [mair_pkg::PIN_W-1:0] pinSel_q,
  output logic pinValid_q
);

  logic [mair_pkg::PIN_W-1:0] pinSel_d;

  // each converter reaches only its own subset of inputs
  function automatic logic [mair_pkg::PIN_W-1:0] route(input int conv, input logic [3:0] code);
    logic [3:0] pin;
    pin = mair_pkg::PIN_NONE;
    unique case (code)
      4'h1: pin = (conv == 0) ? 4'h2 : 4'h0;
      4'h2: pin = (conv == 0 || conv == 2) ? 4'h3 : 4'h0;
      4'h3: pin = (conv == 0 || conv == 1) ? 4'h5 : 4'h0;
      4'h4: pin = 4'h6;
      4'h5: pin = (conv != 3) ? 4'h8 : 4'h0;
      4'h6: pin = (conv != 3) ? 4'ha : 4'h0;
      4'h9: pin = (conv == 0 || conv == 3) ? 4'h1 : 4'h0;
      4'hb: pin = (conv == 0 || conv == 1) ? 4'h4 : 4'h0;
      4'hd: pin = (conv != 3) ? 4'h7 : 4'h0;
      4'he: pin = (conv != 3) ? 4'h9 : 4'h0;
      default: pin = 4'h0;
    endcase
    return pin;
  endfunction

  // switch opens entirely while manual routing is off
  always_comb begin
    pinSel_d = manualEn ? route(CONV, selCode) : mair_pkg::PIN_NONE;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinSel_q <= mair_pkg::PIN_NONE;
      pinValid_q <= 1'b0;
    end else begin
      pinSel_q <= pinSel_d;
      pinValid_q <= (pinSel_d != mair_pkg::PIN_NONE);
    end
  end

  a_open_when_off: assert property (@(posedge clk) disable iff (!rst_b)
    !manualEn |=> (pinSel_q == 4'h0) && !pinValid_q)
    else $error("switch closed while manual routing off");

  a_unlisted_open: assert property (@(posedge clk) disable iff (!rst_b)
    (selCode == 4'h7 || selCode == 4'h8 || selCode == 4'ha || selCode == 4'hc || selCode == 4'hf)
    |=> pinSel_q == 4'h0)
    else $error("unlisted code connected an input");

  // converter 3 reaches only two inputs; a slip in its table shows here
  a_valid_tracks: assert property (@(posedge clk) disable iff (!rst_b)
    pinValid_q == (pinSel_q != 4'h0) && (!pinValid_q || CONV != 3 || pinSel_q == 4'h6 || pinSel_q == 4'h1))
    else $error("valid flag disagrees with routed input");

endmodule

/* File: rtl/mair_route_ctrl.sv */
// mair_route_ctrl: manual analog input route control, Wishbone register file plus four switch decoders.
// assumes a classic Wishbone master on clk; switch outputs drive the analog mux controls.
//
// Behaviour
// - enable bit C4[7] makes switches follow selects
// - routing touches only switches, not downstream format
// - four independent muxes, each 4-bit select
// - converter 0 select C3[3:0] decode table
// - converter 1 select C3[7:4] decode table
// - converter 2 select C4[3:0] decode table
// - converter 3 select F3[7:4]: inputs 6, 1
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
module mair_route_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mair_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic manualRouteEnable,
  output logic [mair_pkg::NUM_CONV*mair_pkg::PIN_W-1:0] convInput,
  output logic [mair_pkg::NUM_CONV-1:0] convConnected
);

  logic [7:0] sel01_q, sel01_d;
  logic [7:0] enSel2_q, enSel2_d;
  logic [7:0] sel3_q, sel3_d;
  logic ack_q, ack_d;
  logic err_q, err_d;
  logic [31:0] rdat_q, rdat_d;
  logic [mair_pkg::SEL_W-1:0] selCode [mair_pkg::NUM_CONV];
  logic req;
  logic hit;
  logic wrLane0;

  function automatic logic isMapped(input logic [mair_pkg::ADDR_W-1:0] a);
    return (a == mair_pkg::ADDR_SEL01) || (a == mair_pkg::ADDR_EN_SEL2)
        || (a == mair_pkg::ADDR_SEL3) || (a == mair_pkg::ADDR_ROUTE_STATUS);
  endfunction

  // one answer per request; ack drops the cycle after it is given
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign hit = isMapped(wb_adr_i);
  assign wrLane0 = req && hit && wb_we_i && wb_sel_i[0];

  always_comb begin
    sel01_d = sel01_q;
    enSel2_d = enSel2_q;
    sel3_d = sel3_q;
    // only the switch controls live here; format fields are elsewhere
    if (wrLane0) begin
      unique case (wb_adr_i)
        mair_pkg::ADDR_SEL01: sel01_d = wb_dat_i[7:0] & mair_pkg::MASK_SEL01;
        mair_pkg::ADDR_EN_SEL2: enSel2_d = wb_dat_i[7:0] & mair_pkg::MASK_EN_SEL2;
        mair_pkg::ADDR_SEL3: sel3_d = wb_dat_i[7:0] & mair_pkg::MASK_SEL3;
        default: ;
      endcase
    end
  end

  always_comb begin
    ack_d = req && hit;
    err_d = req && !hit;
    rdat_d = 32'h0000_0000;
    if (req && hit && !wb_we_i) begin
      unique case (wb_adr_i)
        mair_pkg::ADDR_SEL01: rdat_d = {24'h00_0000, sel01_q};
        mair_pkg::ADDR_EN_SEL2: rdat_d = {24'h00_0000, enSel2_q};
        mair_pkg::ADDR_SEL3: rdat_d = {24'h00_0000, sel3_q};
        default: rdat_d = {28'h000_0000, convConnected};
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel01_q <= mair_pkg::RST_SEL01;
      enSel2_q <= mair_pkg::RST_EN_SEL2;
      sel3_q <= mair_pkg::RST_SEL3;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      sel01_q <= sel01_d;
      enSel2_q <= enSel2_d;
      sel3_q <= sel3_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;
  assign manualRouteEnable = enSel2_q[mair_pkg::MAN_EN_BIT];

  assign selCode[0] = sel01_q[mair_pkg::SEL0_LSB +: mair_pkg::SEL_W];
  assign selCode[1] = sel01_q[mair_pkg::SEL1_LSB +: mair_pkg::SEL_W];
  assign selCode[2] = enSel2_q[mair_pkg::SEL2_LSB +: mair_pkg::SEL_W];
  assign selCode[3] = sel3_q[mair_pkg::SEL3_LSB +: mair_pkg::SEL_W];

  // each converter's switch has its own select and decoder
  for (genvar c = 0; c < mair_pkg::NUM_CONV; c++) begin : g_conv
    mair_route_decode #(
      .CONV(c)
    ) u_dec (
      .clk(clk),
      .rst_b(rst_b),
      .manualEn(manualRouteEnable),
      .selCode(selCode[c]),
      .pinSel_q(convInput[c*mair_pkg::PIN_W +: mair_pkg::PIN_W]),
      .pinValid_q(convConnected[c])
    );
  end

  a_write_enable: assert property (@(posedge clk) disable iff (!rst_b)
    wrLane0 && wb_adr_i == mair_pkg::ADDR_EN_SEL2 |=> manualRouteEnable == $past(wb_dat_i[7]))
    else $error("enable bit not taken from write");

  a_route_graphics: assert property (@(posedge clk) disable iff (!rst_b)
    manualRouteEnable && selCode[0] == 4'h1 && selCode[1] == 4'h3 && selCode[2] == 4'h2
    |=> convInput[11:0] == 12'h352)
    else $error("graphics routing not 2,5,3");

  a_conv1_table: assert property (@(posedge clk) disable iff (!rst_b)
    manualRouteEnable && selCode[1] == 4'hb |=> convInput[7:4] == 4'h4)
    else $error("converter 1 code b not on input 4");

  a_conv2_table: assert property (@(posedge clk) disable iff (!rst_b)
    manualRouteEnable && selCode[2] == 4'h3 |=> convInput[11:8] == 4'h0)
    else $error("converter 2 code 3 connected");

  a_conv3_table: assert property (@(posedge clk) disable iff (!rst_b)
    manualRouteEnable && selCode[3] == 4'h9 |=> convInput[15:12] == 4'h1)
    else $error("converter 3 code 9 not on input 1");

  a_conv0_table: assert property (@(posedge clk) disable iff (!rst_b)
    manualRouteEnable && selCode[0] == 4'he |=> convInput[3:0] == 4'h9)
    else $error("converter 0 code e not on input 9");

  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_b)
    req |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o && !wb_err_o)
    else $error("bus answer not single one-cycle pulse");

  a_reset_open: assert property (@(posedge clk)
    !rst_b |=> rst_b || (convConnected == 4'h0))
    else $error("converter connected during reset");

  c_graphics: cover property (@(posedge clk) disable iff (!rst_b) convConnected[2:0] == 3'h7);
  c_conv3_on: cover property (@(posedge clk) disable iff (!rst_b) convConnected[3]);
  c_bus_err: cover property (@(posedge clk) disable iff (!rst_b) wb_err_o);

endmodule

/* File: verif/mair_route_ctrl_tb.sv */
// testbench: self-checking bench for the manual analog input route control.
// assumes the block answers every Wishbone request within a few clock cycles.
`timescale 1ns/100ps
module testbench;
  // analog input per select code, code 0 in the lowest nibble
  localparam logic [63:0] TAB0 = 64'h0970_4010_0a86_5320;
  localparam logic [63:0] TAB1 = 64'h0970_4000_0a86_5000;
  localparam logic [63:0] TAB2 = 64'h0970_0000_0a86_0300;
  localparam logic [63:0] TAB3 = 64'h0000_0010_0006_0000;
  logic clk = 1'b0, rstB = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [9:0] wbAdr = 10'h000;
  logic [31:0] wbDatI = 32'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatO;
  logic wbAck, wbErr, manualRouteEnable;
  logic [15:0] convInput;
  logic [3:0] convConnected;
  int mismatches = 0, checked = 0;
  always #50 clk = ~clk;
  mair_route_ctrl i_mair_route_ctrl (.clk(clk), .rst_b(rstB), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .wb_err_o(wbErr), .manualRouteEnable(manualRouteEnable),
    .convInput(convInput), .convConnected(convConnected));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; the trailing idle edge also lets the route outputs settle
  task automatic wb(input logic we, input logic [9:0] adr, input logic [7:0] dat, input logic [3:0] sel,
    output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= {24'h0, dat};
    wbSel <= sel;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
    rd = wbDatO;
    er = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1 && wbErr !== 1'b1) begin
      mismatches++;
      summarize();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] adr, input logic [7:0] dat);
    logic [31:0] rd;
    logic er;
    wb(1'b1, adr, dat, 4'h1, rd, er);
  endtask
  task automatic rdChk(input string what, input logic [9:0] adr, input logic [7:0] exp);
    logic [31:0] rd;
    logic er;
    wb(1'b0, adr, 8'h00, 4'hf, rd, er);
    check(what, rd, {24'h0, exp});
  endtask
  task automatic testReset();
    check("route outputs", {manualRouteEnable, convConnected, convInput}, 32'h0);
    rdChk("sel01 reset", mair_pkg::ADDR_SEL01, 8'h00);
    rdChk("en sel2 reset", mair_pkg::ADDR_EN_SEL2, 8'h00);
    rdChk("sel3 reset", mair_pkg::ADDR_SEL3, 8'h00);
    $display("test reset done");
  endtask
  task automatic testDecode();
    logic [15:0] expIn;
    logic [3:0] expCon;
    for (int c = 0; c < 16; c++) begin
      wr(mair_pkg::ADDR_SEL01, {c[3:0], c[3:0]});
      wr(mair_pkg::ADDR_EN_SEL2, {4'hf, c[3:0]});
      wr(mair_pkg::ADDR_SEL3, {c[3:0], 4'hf});
      expIn = {TAB3[4*c +: 4], TAB2[4*c +: 4], TAB1[4*c +: 4], TAB0[4*c +: 4]};
      for (int k = 0; k < 4; k++) expCon[k] = (expIn[4*k +: 4] != 4'h0);
      check("converter inputs", convInput, expIn);
      check("connected flags", convConnected, expCon);
      check("manual enable", manualRouteEnable, 1'b1);
      rdChk("en sel2 readback", mair_pkg::ADDR_EN_SEL2, {4'h8, c[3:0]});
      rdChk("sel3 readback", mair_pkg::ADDR_SEL3, {c[3:0], 4'h0});
      rdChk("status", mair_pkg::ADDR_ROUTE_STATUS, {4'h0, expCon});
    end
    $display("test decode done");
  endtask
  task automatic testDisable();
    wr(mair_pkg::ADDR_SEL01, 8'h44);
    wr(mair_pkg::ADDR_SEL3, 8'h40);
    wr(mair_pkg::ADDR_EN_SEL2, 8'h84);
    check("all on input six", convInput, 16'h6666);
    wr(mair_pkg::ADDR_EN_SEL2, 8'h04);
    check("disabled inputs", convInput, 16'h0000);
    check("disabled flags", convConnected, 4'h0);
    check("enable cleared", manualRouteEnable, 1'b0);
    rdChk("selects kept", mair_pkg::ADDR_SEL01, 8'h44);
    $display("test disable done");
  endtask
  task automatic testRgbAndBus();
    logic [31:0] rd;
    logic er;
    // format fields live in the downstream processors; only switches are set here
    wr(mair_pkg::ADDR_SEL01, 8'h31);
    wr(mair_pkg::ADDR_SEL3, 8'h00);
    wr(mair_pkg::ADDR_EN_SEL2, 8'h82);
    check("rgb routing", convInput, 16'h0352);
    wb(1'b1, mair_pkg::ADDR_SEL01, 8'h00, 4'h0, rd, er);
    check("masked write", convInput, 16'h0352);
    wb(1'b1, 10'h000, 8'hff, 4'h1, rd, er);
    check("unmapped write err", er, 1'b1);
    wb(1'b0, 10'h3fc, 8'h00, 4'hf, rd, er);
    check("unmapped read err", er, 1'b1);
    wr(mair_pkg::ADDR_ROUTE_STATUS, 8'h00);
    rdChk("status read only", mair_pkg::ADDR_ROUTE_STATUS, 8'h07);
    check("routing kept", convInput, 16'h0352);
    $display("test rgb and bus done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstB <= 1'b1;
    testReset();
    testDecode();
    testDisable();
    testRgbAndBus();
    summarize();
  end
endmodule
